/* hdl/ppw_port.sv */
// Functional notes
// - every pin but input-only has pull-up/down
// - polarity bit: one up, zero down
// - separate enable switches the selected resistor
// - pulls off: output, alternate, reset, disable
// - input-only pull-up on master clear, off programming
// - port read returns current pin levels
// - direction one inputs, zero drives latch
// - input-only direction bit always reads one
// - crystal modes read pin 5,4 direction one
// - per-pin change enables, reset to zero
// - power-on reset disables all change detection
// - enabled mismatches against last read set flag
// - mismatch keeps setting flag until port accessed
// - last-read latch survives soft resets
// - change during port read still sets flag
// - pending change wakes device from sleep
// - crystal modes read pin 5,4 enables zero
// - input-only enable ignored in wake-reset sleep
// - wake vectors if global enable, else continues
// - low-power wake enable turns sink on while pin 0 is an input
// - discharge below low threshold raises change
// - port write loads the latch from write data
// - analog pins read zero
`include "ppw_cfg.svh"
module ppw_port import ppw_pkg::*; #(
  parameter int NPIN = 6
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic por,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [NPIN-1:0] pin_in,
  input wire logic [NPIN-1:0] analog_sel,
  input wire logic [NPIN-1:0] alt_func,
  input wire ppw_cfg_t cfg,
  input wire logic prog_hv,
  input wire logic sleep_req,
  output ppw_pad_t pad,
  output logic change_irq_flag,
  output logic wake,
  output logic vector_take
);
  initial begin
    if (NPIN != 6) $error("ppw_port supports exactly six pins");
  end
  logic [5:0] pin_s;
  logic [5:0] dir_r, dir_nxt;
  logic [5:0] latch_r, latch_nxt;
  logic [5:0] pull_en_r, pull_pol_r, ioc_r;
  logic [5:0] last_rd_r;
  logic pull_dis_r, lpw_en_r, gie_r, flag_r, flag_nxt;
  logic [7:0] rdata_r;
  ppw_state_t st_r, st_nxt;
  ppw_sync #(.W(6)) u_sync (.clock(clock), .rst(rst), .d(pin_in), .q(pin_s));

  // decode
  wire hit_lvl = addr == `PPW_OFS_LEVELS;
  wire hit_dir = addr == `PPW_OFS_DIR;
  wire hit_pen = addr == `PPW_OFS_PULL_EN;
  wire hit_ioc = addr == `PPW_OFS_IOC_EN;
  wire hit_pol = addr == `PPW_OFS_PULL_POL;
  wire hit_ctl = addr == `PPW_OFS_CTRL;
  wire hit_sts = addr == `PPW_OFS_STATUS;
  wire xtal = cfg.osc_mode == PPW_OSC_XT || cfg.osc_mode == PPW_OSC_HS
      || cfg.osc_mode == PPW_OSC_LP;
  wire [5:0] osc_pins = xtal ? `PPW_OSC_PIN_MASK : 6'h00;

  // visible views of the registers
  wire [5:0] levels_view = pin_s & ~analog_sel;
  wire [5:0] dir_view = dir_r | `PPW_IN_ONLY_MASK | osc_pins;
  wire [5:0] ioc_view = ioc_r & ~osc_pins;

  // change detection; the input-only enable drops out in wake-reset sleep
  wire asleep = st_r == PPW_SLEEP;
  wire wur_sleep = cfg.wake_reset_en && asleep;
  wire [5:0] ioc_eff = ioc_view & ~(wur_sleep ? `PPW_IN_ONLY_MASK : 6'h00);
  wire port_acc = hit_lvl && (rd || wr);
  wire [5:0] mism = (pin_s ^ last_rd_r) & ioc_eff;
  wire any_mism = |mism;
  // a clear lands only after the mismatch is gone; set wins over clear
  wire flag_clr = wr && hit_ctl && !wdata[`PPW_CTRL_FLAG];
  always_comb begin
    flag_nxt = flag_r;
    if (flag_clr) flag_nxt = 1'b0;
    if (any_mism) flag_nxt = 1'b1;
  end

  // port write loads the output latch straight from the write data
  always_comb begin
    latch_nxt = latch_r;
    if (wr && hit_lvl) latch_nxt = wdata[5:0];
    dir_nxt = dir_r;
    if (wr && hit_dir) dir_nxt = wdata[5:0] | `PPW_IN_ONLY_MASK;
  end

  // sleep tracking for wake and vector decision
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      PPW_RUN: if (sleep_req && !flag_r) st_nxt = PPW_SLEEP;
      PPW_SLEEP: if (flag_r) st_nxt = PPW_WOKE;
      PPW_WOKE: st_nxt = PPW_RUN;
      default: st_nxt = PPW_RUN;
    endcase
  end
  assign wake = st_r == PPW_WOKE;
  assign vector_take = wake && gie_r;

  // last-read latch: only power-on clears it
  always_ff @(posedge clock) begin
    if (por) last_rd_r <= '0;
    else if (port_acc) last_rd_r <= pin_s;
  end

  // enables: power-on and other resets both zero them
  always_ff @(posedge clock) begin
    if (rst || por) ioc_r <= `PPW_IOC_RST;
    else if (wr && hit_ioc) ioc_r <= wdata[5:0];
  end

  // control state
  always_ff @(posedge clock) begin
    if (rst || por) begin
      dir_r <= `PPW_DIR_RST;
      latch_r <= '0;
      pull_en_r <= `PPW_PULL_RST;
      pull_pol_r <= `PPW_PULL_RST;
      pull_dis_r <= 1'b1;
      lpw_en_r <= 1'b0;
      gie_r <= 1'b0;
      st_r <= PPW_RUN;
    end else begin
      dir_r <= dir_nxt;
      latch_r <= latch_nxt;
      st_r <= st_nxt;
      if (wr && hit_pen) pull_en_r <= wdata[5:0] & `PPW_PULL_MASK;
      if (wr && hit_pol) pull_pol_r <= wdata[5:0] & `PPW_PULL_MASK;
      if (wr && hit_ctl) begin
        pull_dis_r <= wdata[`PPW_CTRL_PULL_DIS];
        lpw_en_r <= wdata[`PPW_CTRL_LPW_EN];
        gie_r <= wdata[`PPW_CTRL_GIE];
      end
    end
  end

  // flag survives soft reset alongside the latch so a mismatch re-sets it
  always_ff @(posedge clock) begin
    if (por) flag_r <= 1'b0;
    else flag_r <= flag_nxt;
  end
  assign change_irq_flag = flag_r;

  // pad drive: pulls only on idle inputs
  wire [5:0] in_idle = dir_view & ~alt_func & ~analog_sel;
  wire pulls_ok = !pull_dis_r && !por;
  wire [5:0] pull_on = pulls_ok ? (pull_en_r & in_idle & `PPW_PULL_MASK) : 6'h00;
  wire master_clear_pull = cfg.master_clear_en && !prog_hv;
  assign pad.out = latch_r;
  assign pad.oe = ~dir_view;
  assign pad.pull_up_on = (pull_on & pull_pol_r) | (master_clear_pull ? `PPW_IN_ONLY_MASK : 6'h00);
  assign pad.pull_dn_on = pull_on & ~pull_pol_r;
  assign pad.sink_on = lpw_en_r && dir_view[`PPW_PIN_WAKE];

  // read data, valid the cycle after the strobe
  wire [7:0] ctl_view = {4'h0, flag_r, gie_r, lpw_en_r, pull_dis_r};
  wire [7:0] sts_view = {6'h00, any_mism, flag_r};
  wire [7:0] rd_mux =
      hit_lvl ? {2'h0, levels_view} :
      hit_dir ? {2'h0, dir_view} :
      hit_pen ? {2'h0, pull_en_r} :
      hit_ioc ? {2'h0, ioc_view} :
      hit_pol ? {2'h0, pull_pol_r} :
      hit_ctl ? ctl_view :
      hit_sts ? sts_view : 8'h00;
  always_ff @(posedge clock) begin
    if (rst) rdata_r <= '0;
    else rdata_r <= rd ? rd_mux : 8'h00;
  end
  assign rdata = rdata_r;

  // checks
  chk_flag_set_mism: assert property (@(posedge clock) disable iff (rst || por)
      any_mism |=> flag_r) else $error("mismatch did not set flag");
  chk_flag_hold: assert property (@(posedge clock) disable iff (rst || por)
      any_mism && flag_clr |=> flag_r) else $error("clear beat mismatch");
  chk_dir_in_only: assert property (@(posedge clock) disable iff (rst)
      dir_view[`PPW_PIN_IN_ONLY]) else $error("input-only direction cleared");
  chk_ioc_xtal: assert property (@(posedge clock) disable iff (rst)
      xtal |-> ioc_view[5:4] == 2'h0) else $error("crystal enables visible");
  chk_pull_output: assert property (@(posedge clock) disable iff (rst)
      ((pad.pull_up_on | pad.pull_dn_on) & pad.oe) == 6'h00)
      else $error("pull on driven pin");
  chk_pull_pdis: assert property (@(posedge clock) disable iff (rst)
      pull_dis_r |-> pad.pull_dn_on == 6'h00) else $error("pull not disabled");
  sequence s_asleep_flag;
    asleep ##0 flag_r;
  endsequence
  chk_wake_seq: assert property (@(posedge clock) disable iff (rst || por)
      s_asleep_flag |=> wake ##1 !wake) else $error("no wake on flag");
  chk_vector_gie: assert property (@(posedge clock) disable iff (rst)
      wake && !gie_r |-> !vector_take) else $error("vector without enable");
  chk_ioc_reset: assert property (@(posedge clock)
      $past(por) |-> ioc_r == 6'h00) else $error("enables not cleared");
  chk_rd_levels: assert property (@(posedge clock) disable iff (rst)
      rd && hit_lvl |=> rdata == {2'h0, $past(levels_view)})
      else $error("port read wrong");
endmodule

/* common/ppw_cfg.svh */
`ifndef PPW_CFG_SVH
`define PPW_CFG_SVH
// register offsets on the plain register port
`define PPW_OFS_LEVELS 8'h05
`define PPW_OFS_DIR 8'h85
`define PPW_OFS_PULL_EN 8'h95
`define PPW_OFS_IOC_EN 8'h96
`define PPW_OFS_PULL_POL 8'h97
`define PPW_OFS_CTRL 8'h98
`define PPW_OFS_STATUS 8'h99
// implemented-bit masks and reset values
`define PPW_PULL_MASK 6'h37
`define PPW_DIR_RST 6'h3F
`define PPW_PULL_RST 6'h37
`define PPW_IOC_RST 6'h00
`define PPW_IN_ONLY_MASK 6'h08
`define PPW_OSC_PIN_MASK 6'h30
// pin positions
`define PPW_PIN_IN_ONLY 3
`define PPW_PIN_WAKE 0
`define PPW_PIN_OSC_LO 4
`define PPW_PIN_OSC_HI 5
// control register fields
`define PPW_CTRL_PULL_DIS 0
`define PPW_CTRL_LPW_EN 1
`define PPW_CTRL_GIE 2
`define PPW_CTRL_FLAG 3
// status register fields
`define PPW_STAT_FLAG 0
`define PPW_STAT_MISMATCH 1
`endif

/* common/ppw_pkg.sv */
package ppw_pkg;
  // device-wide configuration that this port only observes
  typedef struct packed {
    logic [2:0] osc_mode;
    logic master_clear_en;
    logic wake_reset_en;
  } ppw_cfg_t;
  typedef enum logic [2:0] {
    PPW_OSC_INT = 3'h0,
    PPW_OSC_EXT = 3'h1,
    PPW_OSC_XT = 3'h2,
    PPW_OSC_HS = 3'h3,
    PPW_OSC_LP = 3'h4
  } ppw_osc_t;
  // per-pin drive to the pad ring
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
    logic [5:0] pull_up_on;
    logic [5:0] pull_dn_on;
    logic sink_on;
  } ppw_pad_t;
  typedef enum {PPW_RUN, PPW_SLEEP, PPW_WOKE} ppw_state_t;
endpackage

/* hdl/ppw_sync.sv */
`include "ppw_cfg.svh"
// two-flop synchroniser for the pin levels
module ppw_sync import ppw_pkg::*; #(
  parameter int W = 6
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  initial begin
    if (W < 1) $error("ppw_sync width must be positive");
  end
  // first stage is read only by the second
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

/* dv/ppw_pins.sv */
// pad ring with a charged capacitor on the wake-capable pin
module ppw_pins import ppw_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire ppw_pad_t pad,
  input wire logic [5:0] ext,
  output logic [5:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cap_r;
  // charges while driven high, drains only through the sink
  always @(posedge clock) begin
    if (rst) begin
      cap_r <= 8'h00;
    end else if (pad.oe[0] && pad.out[0]) begin
      cap_r <= 8'hFF;
    end else if (pad.sink_on && cap_r != 8'h00) begin
      cap_r <= cap_r - 8'h01;
    end
  end
  // a driver beats a pull, a pull beats the outside
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin_in[i] = pad.oe[i] ? pad.out[i] : pad.pull_up_on[i] ? 1'b1 :
        pad.pull_dn_on[i] ? 1'b0 : (i == 0) ? cap_r[7] : ext[i];
    end
  end
endmodule

/* dv/tb_port_pull_change_wake.sv */
`include "ppw_cfg.svh"
module tb_port_pull_change_wake import ppw_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sleep_req = 1'b0;
  logic prog_hv = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [5:0] ext = 6'h2A;
  logic [5:0] pin_in;
  logic [5:0] analog = 6'h00;
  logic [5:0] alt = 6'h00;
  ppw_cfg_t cfg = '0;
  ppw_pad_t pad;
  logic flag, wake, vt;
  int n_errors = 0;
  int checks = 0;
  always #5 clock = ~clock;
  ppw_port dut_u (.clock(clock), .rst(rst), .por(por), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pin_in(pin_in), .analog_sel(analog), .alt_func(alt), .cfg(cfg),
    .prog_hv(prog_hv), .sleep_req(sleep_req), .pad(pad), .change_irq_flag(flag),
    .wake(wake), .vector_take(vt));
  ppw_pins pins_u (.clock(clock), .rst(rst), .pad(pad), .ext(ext), .pin_in(pin_in));
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bus cycles: strobe for one edge, read data in the next cycle only
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 cmp(rdata, e);
  endtask
  task automatic pchk(input logic [5:0] up, input logic [5:0] dn);
    #1 cmp({2'h0, pad.pull_up_on}, {2'h0, up});
    cmp({2'h0, pad.pull_dn_on}, {2'h0, dn});
  endtask
  // bounded wait on the flag or the wake pulse
  task automatic waitfor(input bit w);
    for (int i = 0; i < 400; i++) begin
      @(posedge clock);
      #1;
      if ((w ? wake : flag) === 1'b1) return;
    end
    cmp(8'h00, 8'h01);
    report_and_stop();
  endtask
  task automatic pulse(input bit p);
    @(posedge clock);
    if (p) por <= 1'b1;
    else rst <= 1'b1;
    @(posedge clock);
    por <= 1'b0;
    rst <= 1'b0;
  endtask
  task automatic s_reset();
    rchk(`PPW_OFS_DIR, 8'h3F);
    rchk(`PPW_OFS_IOC_EN, 8'h00);
    rchk(`PPW_OFS_PULL_POL, 8'h37);
    rchk(`PPW_OFS_PULL_EN, 8'h37);
    rchk(8'h10, 8'h00);
    rchk(`PPW_OFS_LEVELS, 8'h2A);
    analog <= 6'h02;
    rchk(`PPW_OFS_LEVELS, 8'h28);
    analog <= 6'h00;
  endtask
  task automatic s_dir();
    wreg(`PPW_OFS_DIR, 8'h00);
    #1 cmp({2'h0, pad.oe}, 8'h37);
    rchk(`PPW_OFS_DIR, 8'h08);
    cfg.osc_mode <= PPW_OSC_XT;
    rchk(`PPW_OFS_DIR, 8'h38);
    cfg.osc_mode <= PPW_OSC_LP;
    rchk(`PPW_OFS_DIR, 8'h38);
    cfg.osc_mode <= PPW_OSC_HS;
    rchk(`PPW_OFS_DIR, 8'h38);
    wreg(`PPW_OFS_IOC_EN, 8'h3F);
    rchk(`PPW_OFS_IOC_EN, 8'h0F);
    cfg.osc_mode <= PPW_OSC_INT;
    wreg(`PPW_OFS_IOC_EN, 8'h00);
    wreg(`PPW_OFS_DIR, 8'h3F);
  endtask
  // polarity and enable act apart; outputs and the disable bit win
  task automatic s_pull();
    wreg(`PPW_OFS_CTRL, 8'h00);
    pchk(6'h37, 6'h00);
    wreg(`PPW_OFS_PULL_POL, 8'h05);
    pchk(6'h05, 6'h32);
    wreg(`PPW_OFS_PULL_EN, 8'h21);
    pchk(6'h01, 6'h20);
    alt <= 6'h20;
    pchk(6'h01, 6'h00);
    alt <= 6'h00;
    wreg(`PPW_OFS_DIR, 8'h3E);
    pchk(6'h00, 6'h20);
    wreg(`PPW_OFS_CTRL, 8'h01);
    cfg.master_clear_en <= 1'b1;
    pchk(6'h08, 6'h00);
    prog_hv <= 1'b1;
    @(posedge clock);
    pchk(6'h00, 6'h00);
    prog_hv <= 1'b0;
    cfg.master_clear_en <= 1'b0;
    wreg(`PPW_OFS_DIR, 8'h3F);
  endtask
  // flag keeps coming back until the port is read; soft reset keeps the latch
  task automatic s_change();
    rchk(`PPW_OFS_LEVELS, 8'h2A);
    wreg(`PPW_OFS_IOC_EN, 8'h02);
    ext <= 6'h28;
    waitfor(1'b0);
    wreg(`PPW_OFS_CTRL, 8'h01);
    rchk(`PPW_OFS_STATUS, 8'h03);
    pulse(1'b0);
    #1 cmp({7'h00, flag}, 8'h01);
    wreg(`PPW_OFS_CTRL, 8'h01);
    wreg(`PPW_OFS_IOC_EN, 8'h02);
    rchk(`PPW_OFS_STATUS, 8'h03);
    rchk(`PPW_OFS_LEVELS, 8'h28);
    wreg(`PPW_OFS_CTRL, 8'h01);
    rchk(`PPW_OFS_STATUS, 8'h00);
    pulse(1'b1);
    rchk(`PPW_OFS_IOC_EN, 8'h00);
  endtask
  // charge, enable, input, sink on, sleep; vector taken with global enable
  task automatic s_wake();
    wreg(`PPW_OFS_LEVELS, 8'h01);
    wreg(`PPW_OFS_DIR, 8'h3E);
    // let the charged level pass the two-flop synchroniser before the read
    repeat (4) @(posedge clock);
    #1 cmp({2'h0, pad.out}, 8'h01);
    rchk(`PPW_OFS_LEVELS, 8'h29);
    wreg(`PPW_OFS_IOC_EN, 8'h01);
    wreg(`PPW_OFS_DIR, 8'h3F);
    wreg(`PPW_OFS_CTRL, 8'h07);
    #1 cmp({7'h00, pad.sink_on}, 8'h01);
    sleep_req <= 1'b1;
    @(posedge clock);
    sleep_req <= 1'b0;
    waitfor(1'b1);
    cmp({7'h00, vt}, 8'h01);
  endtask
  // input-only enable is ignored in wake-reset sleep, then wakes without vector
  task automatic s_wur();
    rchk(`PPW_OFS_LEVELS, 8'h28);
    wreg(`PPW_OFS_CTRL, 8'h01);
    rchk(`PPW_OFS_STATUS, 8'h00);
    wreg(`PPW_OFS_IOC_EN, 8'h08);
    cfg.wake_reset_en <= 1'b1;
    sleep_req <= 1'b1;
    @(posedge clock);
    sleep_req <= 1'b0;
    @(posedge clock);
    ext <= 6'h20;
    repeat (8) @(posedge clock);
    #1 cmp({7'h00, flag}, 8'h00);
    cfg.wake_reset_en <= 1'b0;
    waitfor(1'b1);
    cmp({7'h00, vt}, 8'h00);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    por <= 1'b0;
    s_reset();
    s_dir();
    s_pull();
    s_change();
    s_wake();
    s_wur();
    report_and_stop();
  end
endmodule
